// [fsf_pkg.sv]
// shared constants and types for the supervisory flash function sequencer
package fsf_pkg;

    // =========================================================
    // register and parameter block offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h01;
    localparam logic [7:0] OFS_ACC = 8'h02;
    localparam logic [7:0] OFS_IDX = 8'h03;
    localparam logic [4:0] OFS_PARAM_TOP = 5'h1f;
    localparam logic [7:0] OFS_FIRST_KEY_BYTE = 8'hf8;
    localparam logic [7:0] OFS_SECOND_KEY_BYTE = 8'hf9;
    localparam logic [7:0] OFS_BLKSEL = 8'hfa;
    localparam logic [7:0] OFS_CLKDIV = 8'hfc;
    localparam logic [7:0] OFS_DELAY = 8'hfe;

    // =========================================================
    // field positions and fixed values
    localparam int CTRL_START_BIT = 7;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_KEYERR_BIT = 1;
    localparam logic [7:0] FIRST_KEY_BYTE_VALUE = 8'h3a;
    localparam logic [7:0] TRIM_INDEX_VALUE = 8'hff;
    localparam logic [2:0] IDX_FIRST_KEY_BYTE = 3'h0;
    localparam logic [2:0] IDX_SECOND_KEY_BYTE = 3'h1;
    localparam logic [2:0] IDX_BLKSEL = 3'h2;
    localparam logic [2:0] IDX_CLKDIV = 3'h4;
    localparam logic [2:0] IDX_DELAY = 3'h6;

    // =========================================================
    // sizes and counts
    localparam int PARAM_BYTES = 8;
    localparam logic [14:0] TABLE_BYTES = 15'h0008;
    localparam int BLOCK_SHIFT = 6;
    localparam logic [1:0] USER_LAST_STEP = 2'h2;
    localparam logic [1:0] PROT_LAST_STEP = 2'h1;

    // =========================================================
    // reset values
    localparam logic [7:0] PARAM_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [15:0] SUM_RESET = 16'h0000;

    typedef enum logic [1:0] {FN_WIPE, FN_TABLE, FN_CSUM, FN_NONE} fsf_func_t;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM, OP_READ} fsf_op_t;
    typedef enum logic [1:0] {SP_USER, SP_PROTECT, SP_INFO, SP_HIDDEN} fsf_space_t;

    typedef struct packed {
        fsf_op_t op;
        fsf_space_t space;
        logic [1:0] macro;
        logic [13:0] addr;
        logic [7:0] wdata;
    } fsf_flash_cmd_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fsf_bus_req_t;

endpackage : fsf_pkg

// [fsf_pulse_timer.sv]
// programming pulse timer: width set by divider and delay bytes
`timescale 1ns/1ps
`default_nettype none
module fsf_pulse_timer (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // control
    input wire logic i_start,
    input wire logic [7:0] i_divider,
    input wire logic [7:0] i_delay,
    // status
    output logic o_busy,
    output logic o_done
);
    logic [7:0] pre_q;
    logic [7:0] tick_q;
    logic [7:0] delay_q;
    logic [16:0] len_q;
    logic [16:0] seen_q;
    wire last = (pre_q == 8'h00) && (tick_q == 8'h00);

    // =========================================================
    // (divider + 1) ticks of (delay + 1) cycles each
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pre_q <= 8'h00;
            tick_q <= 8'h00;
            delay_q <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_start) begin
            pre_q <= i_delay;
            tick_q <= i_divider;
            delay_q <= i_delay;
            o_busy <= 1'b1;
            o_done <= 1'b0;
        end else if (o_busy) begin
            o_busy <= !last;
            o_done <= last;
            pre_q <= (pre_q == 8'h00) ? delay_q : pre_q - 8'h01;
            tick_q <= (pre_q == 8'h00) ? tick_q - 8'h01 : tick_q;
        end else begin
            o_done <= 1'b0;
        end
    end

    // =========================================================
    // checking helpers: expected and measured busy length
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            len_q <= 17'h00000;
            seen_q <= 17'h00000;
        end else if (i_start) begin
            len_q <= 17'({9'h000, i_divider} + 17'h00001) * 17'({9'h000, i_delay} + 17'h00001);
            seen_q <= 17'h00000;
        end else if (o_busy) begin
            seen_q <= seen_q + 17'h00001;
        end
    end

    a_pulse_width: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $rose(o_done) |-> seen_q == len_q)
        else $error("pulse width differs from divider and delay");

endmodule : fsf_pulse_timer
`default_nettype wire

// [fsf_cksum_acc.sv]
// checksum accumulator: byte into low half, carry into high half
`timescale 1ns/1ps
`default_nettype none
module fsf_cksum_acc (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // control and data
    input wire logic i_clear,
    input wire logic i_add,
    input wire logic [7:0] i_byte,
    // result
    output logic [15:0] o_sum
);
    wire [8:0] lo_sum = {1'b0, o_sum[7:0]} + {1'b0, i_byte};
    wire [7:0] hi_sum = o_sum[15:8] + {7'h00, lo_sum[8]};

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sum <= fsf_pkg::SUM_RESET;
        end else if (i_clear) begin
            o_sum <= fsf_pkg::SUM_RESET;
        end else if (i_add) begin
            o_sum <= {hi_sum, lo_sum[7:0]};
        end
    end

    a_carry_add: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        i_add && !i_clear |=> o_sum == $past(o_sum) + {8'h00, $past(i_byte)})
        else $error("checksum step is not add with carry");

endmodule : fsf_cksum_acc
`default_nettype wire

// [fsf_sequencer.sv]
// supervisory flash sequencer: full wipe, info table fetch and checksum
// =========================================================
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fsf_sequencer #(
    parameter int NUM_MACROS = 1,
    parameter logic [1:0] CSUM_MACRO = 2'h0,
    parameter logic [2:0] TRIM_TABLE = 3'h1,
    parameter logic [15:0] REV_ID = 16'h5a01, // arbitrary value
    parameter logic [7:0] REV_COUNT = 8'h00
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset_n,
    // register port
    input wire fsf_pkg::fsf_bus_req_t i_bus,
    output logic [7:0] o_rd_data,
    // processor hand-back
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_acc,
    output logic [7:0] o_idx,
    // flash macros
    output fsf_pkg::fsf_flash_cmd_t o_flash_cmd,
    input wire logic [7:0] i_flash_rdata
);
    localparam logic [1:0] TOP_MACRO = 2'(NUM_MACROS - 1);

    typedef enum logic [3:0] {
        ST_IDLE, ST_CHECK, ST_W_PULSE, ST_W_WAIT, ST_T_READ, ST_T_RESULT,
        ST_C_READ, ST_C_LO, ST_C_HI, ST_DONE
    } fsf_state_t;

    fsf_state_t st_q, st_d;
    fsf_pkg::fsf_func_t func_q;
    logic [7:0] param_q [fsf_pkg::PARAM_BYTES];
    logic [7:0] blk_q;
    logic [1:0] macro_q, macro_d;
    logic [1:0] step_q, step_d;
    logic prot_q, prot_d;
    logic [14:0] cnt_q;
    logic rvalid_q;
    logic [2:0] widx_q;
    logic keyerr_q;
    logic tmr_busy, tmr_done;
    logic [15:0] sum;

    // =========================================================
    // decode of the register port
    wire in_param = (i_bus.addr[7:3] == fsf_pkg::OFS_PARAM_TOP);
    wire go = i_bus.wr && (i_bus.addr == fsf_pkg::OFS_CTRL)
        && i_bus.wdata[fsf_pkg::CTRL_START_BIT] && (st_q == ST_IDLE);
    wire bus_param_wr = i_bus.wr && in_param && (st_q == ST_IDLE);
    wire key_ok = (param_q[fsf_pkg::IDX_FIRST_KEY_BYTE] == fsf_pkg::FIRST_KEY_BYTE_VALUE);

    // =========================================================
    // read data selection
    wire [7:0] status = {6'h00, keyerr_q, st_q != ST_IDLE};
    wire [7:0] rd_mux = in_param ? param_q[i_bus.addr[2:0]]
        : (i_bus.addr == fsf_pkg::OFS_CTRL) ? {6'h00, func_q}
        : (i_bus.addr == fsf_pkg::OFS_STATUS) ? status
        : (i_bus.addr == fsf_pkg::OFS_ACC) ? o_acc
        : (i_bus.addr == fsf_pkg::OFS_IDX) ? o_idx
        : 8'h00;

    // =========================================================
    // read stream for table fetch and checksum
    wire [8:0] blk_total = {blk_q == 8'h00, blk_q};
    wire [14:0] csum_limit = 15'({blk_total, 6'h00});
    wire in_table = (st_q == ST_T_READ);
    wire in_csum = (st_q == ST_C_READ);
    wire [14:0] limit = in_table ? fsf_pkg::TABLE_BYTES : csum_limit;
    wire rd_issue = (in_table || in_csum) && (cnt_q < limit);
    wire drained = (cnt_q == limit) && (o_flash_cmd.op != fsf_pkg::OP_READ) && !rvalid_q;
    wire [13:0] tbl_addr = {8'h00, blk_q[2:0], cnt_q[2:0]};

    // =========================================================
    // wipe pulses only ever aim at user or protection space
    wire w_first = (step_q != 2'h1);
    wire [1:0] w_op = w_first ? fsf_pkg::OP_ERASE : fsf_pkg::OP_PROGRAM;
    wire [1:0] w_space = prot_q ? fsf_pkg::SP_PROTECT : fsf_pkg::SP_USER;
    wire [1:0] w_last = prot_q ? fsf_pkg::PROT_LAST_STEP : fsf_pkg::USER_LAST_STEP;

    fsf_pkg::fsf_flash_cmd_t cmd_d;
    always_comb begin
        cmd_d = '0;
        if (st_q == ST_W_PULSE || (st_q == ST_W_WAIT && !tmr_done)) begin
            cmd_d.op = fsf_pkg::fsf_op_t'(w_op);
            cmd_d.space = fsf_pkg::fsf_space_t'(w_space);
            cmd_d.macro = macro_q;
        end else if (rd_issue) begin
            cmd_d.op = fsf_pkg::OP_READ;
            cmd_d.space = in_table ? fsf_pkg::SP_INFO : fsf_pkg::SP_USER;
            cmd_d.macro = in_table ? 2'h0 : CSUM_MACRO;
            cmd_d.addr = in_table ? tbl_addr : cnt_q[13:0];
        end
    end

    // =========================================================
    // sequencer writes into the parameter block
    wire seq_wr = (rvalid_q && in_table) || st_q == ST_C_LO || st_q == ST_C_HI;
    wire [2:0] seq_idx = (st_q == ST_C_LO) ? fsf_pkg::IDX_FIRST_KEY_BYTE
        : (st_q == ST_C_HI) ? fsf_pkg::IDX_SECOND_KEY_BYTE : widx_q;
    wire [7:0] seq_wd = (st_q == ST_C_LO) ? sum[7:0]
        : (st_q == ST_C_HI) ? sum[15:8] : i_flash_rdata;

    // =========================================================
    // next state and wipe walk
    always_comb begin
        st_d = st_q;
        macro_d = macro_q;
        step_d = step_q;
        prot_d = prot_q;
        case (st_q)
            ST_IDLE: begin
                if (go) begin
                    st_d = ST_CHECK;
                end
            end
            ST_CHECK: begin
                macro_d = TOP_MACRO;
                step_d = 2'h0;
                prot_d = 1'b0;
                if (!key_ok) begin
                    st_d = ST_DONE;
                end else begin
                    case (func_q)
                        fsf_pkg::FN_WIPE: st_d = ST_W_PULSE;
                        fsf_pkg::FN_TABLE: st_d = ST_T_READ;
                        fsf_pkg::FN_CSUM: st_d = ST_C_READ;
                        default: st_d = ST_DONE;
                    endcase
                end
            end
            ST_W_PULSE: begin
                st_d = ST_W_WAIT;
            end
            ST_W_WAIT: begin
                if (tmr_done) begin
                    st_d = ST_W_PULSE;
                    step_d = step_q + 2'h1;
                    if (step_q == w_last) begin
                        step_d = 2'h0;
                        macro_d = macro_q - 2'h1;
                        if (macro_q == 2'h0) begin
                            macro_d = TOP_MACRO;
                            prot_d = 1'b1;
                            if (prot_q) begin
                                st_d = ST_DONE;
                            end
                        end
                    end
                end
            end
            ST_T_READ: begin
                if (drained) begin
                    st_d = ST_T_RESULT;
                end
            end
            ST_T_RESULT: begin
                st_d = ST_DONE;
            end
            ST_C_READ: begin
                if (drained) begin
                    st_d = ST_C_LO;
                end
            end
            ST_C_LO: begin
                st_d = ST_C_HI;
            end
            ST_C_HI: begin
                st_d = ST_DONE;
            end
            ST_DONE: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // =========================================================
    // state, outputs and bookkeeping
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= ST_IDLE;
            func_q <= fsf_pkg::FN_WIPE;
            macro_q <= 2'h0;
            step_q <= 2'h0;
            prot_q <= 1'b0;
            blk_q <= fsf_pkg::PARAM_RESET;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_flash_cmd <= '0;
            o_rd_data <= 8'h00;
            keyerr_q <= 1'b0;
        end else begin
            st_q <= st_d;
            macro_q <= macro_d;
            step_q <= step_d;
            prot_q <= prot_d;
            o_busy <= (st_d != ST_IDLE) && (st_d != ST_DONE);
            o_done <= (st_d == ST_DONE);
            o_flash_cmd <= cmd_d;
            o_rd_data <= i_bus.rd ? rd_mux : 8'h00;
            if (go) begin
                func_q <= fsf_pkg::fsf_func_t'(i_bus.wdata[1:0]);
                keyerr_q <= 1'b0;
            end else if (st_q == ST_CHECK && !key_ok) begin
                keyerr_q <= 1'b1;
            end
            if (st_q == ST_CHECK) begin
                blk_q <= param_q[fsf_pkg::IDX_BLKSEL];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= 15'h0000;
            rvalid_q <= 1'b0;
            widx_q <= 3'h0;
        end else begin
            cnt_q <= (st_q == ST_CHECK) ? 15'h0000 : cnt_q + {14'h0000, rd_issue};
            rvalid_q <= (o_flash_cmd.op == fsf_pkg::OP_READ);
            widx_q <= o_flash_cmd.addr[2:0];
        end
    end

    // only the fetch of a table writes the hand-back bytes
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_acc <= fsf_pkg::RESULT_RESET;
            o_idx <= fsf_pkg::RESULT_RESET;
        end else if (st_q == ST_T_RESULT) begin
            o_acc <= (blk_q[2:0] == TRIM_TABLE) ? REV_COUNT : REV_ID[15:8];
            o_idx <= (blk_q[2:0] == TRIM_TABLE) ? fsf_pkg::TRIM_INDEX_VALUE : REV_ID[7:0];
        end
    end

    // =========================================================
    // parameter block; software writes are dropped while a call runs
    for (genvar i = 0; i < fsf_pkg::PARAM_BYTES; i++) begin : g_param
        always_ff @(posedge i_clock or negedge i_reset_n) begin
            if (!i_reset_n) begin
                param_q[i] <= fsf_pkg::PARAM_RESET;
            end else if (seq_wr && seq_idx == 3'(i)) begin
                param_q[i] <= seq_wd;
            end else if (bus_param_wr && i_bus.addr[2:0] == 3'(i)) begin
                param_q[i] <= i_bus.wdata;
            end
        end
    end

    // =========================================================
    // helpers
    fsf_pulse_timer u_timer (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_start(st_q == ST_W_PULSE),
        .i_divider(param_q[fsf_pkg::IDX_CLKDIV]),
        .i_delay(param_q[fsf_pkg::IDX_DELAY]),
        .o_busy(tmr_busy),
        .o_done(tmr_done)
    );

    fsf_cksum_acc u_acc (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_clear(st_q == ST_CHECK),
        .i_add(rvalid_q && in_csum),
        .i_byte(i_flash_rdata),
        .o_sum(sum)
    );

    // =========================================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    sequence s_csum_store;
        (st_q == ST_C_LO) ##1 (st_q == ST_C_HI) ##1 (st_q == ST_DONE);
    endsequence

    a_hidden_untouched: assert property (
        o_flash_cmd.op inside {fsf_pkg::OP_ERASE, fsf_pkg::OP_PROGRAM}
        |-> o_flash_cmd.space inside {fsf_pkg::SP_USER, fsf_pkg::SP_PROTECT})
        else $error("wipe pulse aimed outside user and protection space");
    a_program_zero: assert property (
        o_flash_cmd.op == fsf_pkg::OP_PROGRAM |-> o_flash_cmd.wdata == 8'h00)
        else $error("bulk program is not all zeros");
    a_prot_after_user: assert property (
        $rose(prot_q) |-> $past(macro_q) == 2'h0 && $past(step_q) == fsf_pkg::USER_LAST_STEP)
        else $error("protection phase began before user space was wiped");
    a_table_select: assert property (
        rd_issue && in_table |=> o_flash_cmd.addr[5:3] == blk_q[2:0]
        && o_flash_cmd.space == fsf_pkg::SP_INFO)
        else $error("table fetch used wrong selector bits");
    a_table_copy: assert property (
        rvalid_q && in_table |=> param_q[$past(widx_q)] == $past(i_flash_rdata))
        else $error("table byte not copied to parameter block");
    a_revision_id: assert property (
        st_q == ST_T_RESULT && blk_q[2:0] != TRIM_TABLE |=> {o_acc, o_idx} == REV_ID)
        else $error("die revision not returned");
    a_trim_index: assert property (
        st_q == ST_T_RESULT && blk_q[2:0] == TRIM_TABLE
        |=> o_idx == fsf_pkg::TRIM_INDEX_VALUE && o_acc == REV_COUNT)
        else $error("trim table hand-back wrong");
    a_csum_span: assert property (
        rd_issue && in_csum |-> cnt_q < 15'({blk_total, 6'h00}))
        else $error("checksum read beyond selected blocks");
    a_csum_result: assert property (
        s_csum_store |=> param_q[fsf_pkg::IDX_FIRST_KEY_BYTE] == sum[7:0]
        && param_q[fsf_pkg::IDX_SECOND_KEY_BYTE] == sum[15:8])
        else $error("checksum not stored in key bytes");
    a_release_clean: assert property (
        $fell(o_busy) |-> o_done && o_flash_cmd.op == fsf_pkg::OP_IDLE && !tmr_busy)
        else $error("processor released with flash work pending");

endmodule : fsf_sequencer
`default_nettype wire

// [fsf_flash_model.sv]
// flash macro model: synchronous read data behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fsf_flash_model (
    // clock and command
    input wire logic i_clock,
    input wire fsf_pkg::fsf_flash_cmd_t i_cmd,
    // read data
    output logic [7:0] o_rdata
);
    // =========================================================
    // stored contents
    // info row: table number and byte index form the low six address bits
    wire logic [7:0] info_byte = 8'h80 ^ {2'h0, i_cmd.addr[5:0]};
    wire logic [7:0] user_byte = i_cmd.addr[7:0] ^ {i_cmd.macro, i_cmd.addr[13:8]};
    initial o_rdata = 8'h00;
    // outside reads the bus moves every cycle so stale data is never seen
    always @(posedge i_clock) begin
        if (i_cmd.op != fsf_pkg::OP_READ) begin
            o_rdata <= ~o_rdata;
        end else if (i_cmd.space == fsf_pkg::SP_INFO) begin
            o_rdata <= info_byte;
        end else begin
            o_rdata <= user_byte;
        end
    end
endmodule : fsf_flash_model
`default_nettype wire

// [fsf_sequencer_tb.sv]
// self-checking bench for the supervisory flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fsf_sequencer_tb;
    // =========================================================
    // design and partner
    localparam logic [7:0] DIV = 8'h01;
    localparam logic [7:0] DLY = 8'h02;
    typedef struct packed {logic [1:0] fn; logic [7:0] blk; logic [15:0] ai;} fsf_row_t;
    logic i_clock;
    logic i_reset_n;
    fsf_pkg::fsf_bus_req_t bus;
    fsf_pkg::fsf_flash_cmd_t cmd;
    logic [7:0] rd_data, acc, idx, fl_rdata, rv;
    logic busy, done;
    logic [5:0] seg_q[$];
    int len_q[$];
    int len = 0;
    int cycles = 0;
    int err_count = 0;
    int n_compared = 0;
    bit hid = 0;
    fsf_row_t rows[6] = '{'{2'h1, 8'h00, 16'h5a01}, '{2'h1, 8'hf9, 16'h00ff},
        '{2'h1, 8'h07, 16'h5a01}, '{2'h2, 8'h01, 16'h5a01}, '{2'h2, 8'h03, 16'h5a01},
        '{2'h2, 8'h00, 16'h5a01}};
    // wipe order as {op, space, macro}: user space top macro down, then protection
    logic [5:0] wseq[10] = '{6'h11, 6'h21, 6'h11, 6'h10, 6'h20, 6'h10, 6'h15, 6'h25,
        6'h14, 6'h24};
    fsf_sequencer #(.NUM_MACROS(2), .CSUM_MACRO(2'h1)) i_dut (.i_clock(i_clock),
        .i_reset_n(i_reset_n), .i_bus(bus), .o_rd_data(rd_data), .o_busy(busy),
        .o_done(done), .o_acc(acc), .o_idx(idx), .o_flash_cmd(cmd), .i_flash_rdata(fl_rdata));
    fsf_flash_model i_flash (.i_clock(i_clock), .i_cmd(cmd), .o_rdata(fl_rdata));
    initial begin
        i_clock = 1'b0;
        forever #20 i_clock = ~i_clock;
    end
    // =========================================================
    // pulse log and hang guard
    always @(posedge i_clock) begin
        cycles++;
        if (cmd.space == fsf_pkg::SP_HIDDEN && cmd.op != fsf_pkg::OP_IDLE) hid = 1;
        if (cmd.op == fsf_pkg::OP_ERASE || cmd.op == fsf_pkg::OP_PROGRAM) begin
            if (len == 0) seg_q.push_back({cmd.op, cmd.space, cmd.macro});
            len++;
        end else if (len != 0) begin
            len_q.push_back(len);
            len = 0;
        end
        if (cycles > 40000) begin
            err_count++;
            stop_test();
        end
    end
    // =========================================================
    // tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus <= '0;
        #1 d = rd_data;
    endtask : rd
    task automatic call(input logic [1:0] fn, input logic [7:0] blk, input logic [7:0] key);
        int n;
        seg_q.delete();
        len_q.delete();
        wr(fsf_pkg::OFS_FIRST_KEY_BYTE, key);
        wr(fsf_pkg::OFS_SECOND_KEY_BYTE, 8'hd3);
        wr(fsf_pkg::OFS_BLKSEL, blk);
        wr(fsf_pkg::OFS_CLKDIV, DIV);
        wr(fsf_pkg::OFS_DELAY, DLY);
        wr(fsf_pkg::OFS_CTRL, {1'b1, 5'h00, fn});
        for (n = 0; n < 20000 && done !== 1'b1; n++) begin
            @(posedge i_clock);
            #1;
            if (done !== 1'b1) chk(busy, 1'b1, "busy");
            // a second start while busy must change nothing
            if (n == 4 && fn == fsf_pkg::FN_WIPE) wr(fsf_pkg::OFS_CTRL, 8'h82);
        end
        chk(busy, 1'b0, "busy at done");
        chk(cmd.op, fsf_pkg::OP_IDLE, "flash op at done");
    endtask : call
    function automatic logic [15:0] csum(input logic [7:0] blk);
        logic [15:0] s;
        logic [13:0] a;
        int n;
        s = 16'h0000;
        n = (blk == 8'h00) ? 16384 : 64 * int'(blk);
        for (int k = 0; k < n; k++) begin
            a = 14'(k);
            s = s + {8'h00, a[7:0] ^ {2'h1, a[13:8]}};
        end
        return s;
    endfunction : csum
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    // =========================================================
    // main sequence
    initial begin
        logic [15:0] s;
        i_reset_n = 1'b0;
        bus = '0;
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1'b1;
        #1;
        chk({14'h0000, busy, done}, 16'h0000, "reset flags");
        chk({acc, idx}, 16'h0000, "reset outputs");
        rd(fsf_pkg::OFS_FIRST_KEY_BYTE, rv);
        chk(rv, fsf_pkg::PARAM_RESET, "param reset");
        rd(8'h40, rv);
        chk(rv, 8'h00, "unmapped read");
        foreach (rows[r]) begin
            call(rows[r].fn, rows[r].blk, fsf_pkg::FIRST_KEY_BYTE_VALUE);
            chk({acc, idx}, rows[r].ai, "acc idx");
            if (rows[r].fn == fsf_pkg::FN_TABLE) begin
                for (int i = 0; i < 8; i++) begin
                    rd(fsf_pkg::OFS_FIRST_KEY_BYTE + 8'(i), rv);
                    chk(rv, 8'h80 ^ {2'h0, rows[r].blk[2:0], 3'(i)}, "table");
                end
            end else begin
                s = csum(rows[r].blk);
                rd(fsf_pkg::OFS_FIRST_KEY_BYTE, rv);
                chk(rv, s[7:0], "sum low");
                rd(fsf_pkg::OFS_SECOND_KEY_BYTE, rv);
                chk(rv, s[15:8], "sum high");
            end
        end
        call(fsf_pkg::FN_WIPE, 8'h00, fsf_pkg::FIRST_KEY_BYTE_VALUE);
        chk(seg_q.size(), 10, "pulse count");
        foreach (wseq[i]) chk(seg_q[i], wseq[i], "wipe order");
        foreach (len_q[i]) chk(len_q[i], (DIV + 1) * (DLY + 1) + 1, "pulse width");
        chk(hid, 1'b0, "hidden touched");
        rd(fsf_pkg::OFS_STATUS, rv);
        chk(rv, 8'h00, "status after wipe");
        call(fsf_pkg::FN_TABLE, 8'h02, 8'h3b);
        rd(fsf_pkg::OFS_STATUS, rv);
        chk(rv, 8'h02, "key refusal");
        call(fsf_pkg::FN_NONE, 8'h00, fsf_pkg::FIRST_KEY_BYTE_VALUE);
        chk(seg_q.size(), 0, "no flash action");
        stop_test();
    end
endmodule : fsf_sequencer_tb
`default_nettype wire
